// >>> bench/ebc_ext_mem.sv
/*
 External memory with READY for the bus controller bench.
 Assumes controller strobes are registered on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ebc_ext_mem (
    input  wire logic        clock,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] ad_out,
    input  wire logic [15:0] ad_oe,
    input  wire logic [15:0] dedicated,
    input  wire logic        rdy_pol,
    input  wire logic [7:0]  rdy_dly,
    output var  logic [15:0] ad_wire,
    output var  logic        ready_pin
);
    logic [15:0] mem [256];
    logic [15:0] addr_r = 16'h0000;
    logic [15:0] last_r = 16'h0000;
    logic [7:0]  cnt_r  = 8'h00;
    logic [15:0] drv;
    logic        strb;
    assign strb = !rd_n || !wr_n;
    // Released bus shows the inverse of the last value: no pull-up to hide a late sample
    assign drv = !rd_n ? mem[addr_r[7:0]] : ~last_r;
    assign ad_wire = (ad_out & ad_oe) | (drv & ~ad_oe);
    // Delay FF withholds READY for good
    assign ready_pin = (strb && cnt_r >= rdy_dly && rdy_dly != 8'hFF) ? rdy_pol : !rdy_pol;
    always @(posedge clock) begin
        last_r <= drv;
        cnt_r <= strb ? cnt_r + 8'h01 : 8'h00;
        if (ale) addr_r <= (ad_oe != 16'h0000) ? ad_out : dedicated;
        if (!wr_n) mem[addr_r[7:0]] <= ad_wire;
    end
endmodule
`default_nettype wire

// >>> bench/external_bus_controller_tb.sv
/*
 Self-checking bench of the external bus controller.
 Assumes ebc_pkg compiled first and ebc_cfg.svh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ebc_cfg.svh"
module external_bus_controller_tb
    import ebc_pkg::*;
;
    logic               clock = 1'b0;
    logic               sys_rst = 1'b1;
    ebc_req_t           cpu_req = '0;
    ebc_win_sel_t [3:0] window_address_select = '0;
    ebc_bus_cfg_t [3:0] window_bus_config = '0;
    ebc_bus_cfg_t       default_bus_config = '0;
    logic [1:0]         addr_space_sel = 2'h0;
    logic               chip_select_early_cfg = 1'b0;
    logic               hold_arbitration_enable = 1'b0;
    logic               port6_bit7_direction = 1'b0;
    logic               hold_n = 1'b1;
    logic               bus_grant_ack_in = 1'b1;
    logic               err_a = 1'b0;
    logic               rdy_pol = 1'b1;
    logic [7:0]         rdy_dly = 8'h00;
    logic               cpu_req_ready, cpu_rsp_done, cpu_rsp_err, ale, rd_n, wr_n, bus_ctl_oe, ready_pin;
    logic               bus_request_out_n, bus_grant_ack_n_out, bus_grant_ack_n_oe;
    logic [15:0]        cpu_rsp_rdata, address_data_port_out, address_data_port_oe, address_data_port_in;
    logic [15:0]        dedicated_address_port, ad_a, oe_s;
    logic [7:0]         upper_address_port, up_a;
    logic [4:0]         chip_select_lines_n, cs_a, cs_b;
    logic [7:0]         msk [4] = '{`EBC_MASK_16M, `EBC_MASK_1M, `EBC_MASK_256K, `EBC_MASK_64K};
    int                 err_total = 0;
    int                 total_checks = 0;
    int                 n_ale, n_strb, n_cyc, k;

    ebc_top dut (.clock, .sys_rst, .clk_en(1'b1), .cpu_req, .cpu_req_ready, .cpu_rsp_done, .cpu_rsp_err,
        .cpu_rsp_rdata, .window_address_select, .window_bus_config, .default_bus_config, .addr_space_sel,
        .chip_select_early_cfg, .hold_arbitration_enable, .port6_bit7_direction, .ale, .rd_n, .wr_n,
        .bus_ctl_oe, .address_data_port_out, .address_data_port_oe, .address_data_port_in,
        .dedicated_address_port, .upper_address_port, .chip_select_lines_n, .ready_pin, .hold_n,
        .bus_request_out_n, .bus_grant_ack_n_out, .bus_grant_ack_n_oe, .bus_grant_ack_n_in(bus_grant_ack_in));

    ebc_ext_mem mem (.clock, .ale, .rd_n, .wr_n, .ad_out(address_data_port_out), .ad_oe(address_data_port_oe),
        .dedicated(dedicated_address_port), .rdy_pol, .rdy_dly, .ad_wire(address_data_port_in), .ready_pin);

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic ebc_bus_cfg_t mk(input ebc_mode_t m, input logic [3:0] w, input logic re, input logic p,
                                        input logic ae);
        return '{1'b1, 1'b1, re, p, ae, 1'b0, 1'b0, w, m};
    endfunction

    // One whole access; valid is dropped in the cycle after done, as the done cycle blocks retake
    task automatic acc(input logic we, input logic [23:0] a, input logic [15:0] d);
        n_ale = 0;
        n_strb = 0;
        n_cyc = 0;
        k = -2;
        @(posedge clock);
        cpu_req <= '{1'b1, we, a, d};
        do begin
            @(posedge clock);
            #1;
            n_cyc++;
            if (ale && n_ale == 0) begin
                k = n_cyc;
                cs_a = chip_select_lines_n;
                ad_a = address_data_port_out;
                up_a = upper_address_port;
            end
            if (n_cyc == k + 1) cs_b = chip_select_lines_n;
            if (ale) n_ale++;
            if (!rd_n || !wr_n) begin
                n_strb++;
                oe_s = address_data_port_oe;
            end
        end while (cpu_rsp_done !== 1'b1 && n_cyc < 200);
        err_a = cpu_rsp_err;
        chk(24'(cpu_rsp_done), 24'h1);
        @(posedge clock);
        cpu_req.valid <= 1'b0;
    endtask

    task automatic t_demux;
        @(posedge clock);
        default_bus_config <= mk(EBC_MODE_DEMUX16, 4'h0, 1'b0, 1'b1, 1'b0);
        acc(1'b1, 24'h000042, 16'h5A3C);
        chk(24'(dedicated_address_port), 24'h42);
        chk(24'(n_strb), 24'h2);
        chk({cs_a, cs_b}, {5'h1F, 5'h1E});
        acc(1'b0, 24'h000042, 16'h0000);
        chk(24'(cpu_rsp_rdata), 24'h5A3C);
        chk(24'(err_a), 24'h0);
    endtask

    task automatic t_windows;
        @(posedge clock);
        window_address_select <= '{'{12'h020, 4'h0}, '{12'h020, 4'h0}, '{12'h010, 4'h1}, '{12'h010, 4'h0}};
        for (int i = 0; i < 4; i++) window_bus_config[i] <= mk(EBC_MODE_MUX16, 4'h1, 1'b0, 1'b1, 1'b1);
        chip_select_early_cfg <= 1'b1;
        acc(1'b1, 24'h010100, 16'hC0DE);
        chk(24'(cs_a), 24'h1B);
        chk(24'(ad_a), 24'h0100);
        chk(24'(n_ale * 16 + n_strb), 24'h23);
        acc(1'b0, 24'h010100, 16'h0000);
        chk(24'(cpu_rsp_rdata), 24'hC0DE);
        acc(1'b0, 24'h020100, 16'h0000);
        chk(24'(cs_a), 24'h0F);
    endtask

    task automatic t_bytes;
        ebc_mode_t m [2] = '{EBC_MODE_MUX8, EBC_MODE_DEMUX8};
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            default_bus_config <= mk(m[i], 4'h0, 1'b0, 1'b1, 1'b0);
            acc(1'b1, 24'h000050, 16'h12C3);
            chk(24'(oe_s), 24'h00FF);
            acc(1'b0, 24'h000050, 16'h0000);
            chk(24'(cpu_rsp_rdata), 24'h00C3);
        end
    endtask

    task automatic t_ready;
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            rdy_pol <= p[0];
            rdy_dly <= 8'd20;
            default_bus_config <= mk(EBC_MODE_DEMUX16, 4'h0, 1'b1, p[0], 1'b0);
            acc(1'b0, 24'h000042, 16'h0000);
            chk(24'(n_strb > 20 && n_strb < 30), 24'h1);
            chk(24'(cpu_rsp_rdata), 24'h5A3C);
        end
        @(posedge clock);
        rdy_dly <= 8'h00;
    endtask

    task automatic t_space;
        @(posedge clock);
        default_bus_config <= mk(EBC_MODE_DEMUX16, 4'h0, 1'b0, 1'b1, 1'b0);
        for (int s = 0; s < 4; s++) begin
            @(posedge clock);
            addr_space_sel <= s[1:0];
            acc(1'b0, 24'hAB0042, 16'h0000);
            chk(24'(up_a), 24'(8'hAB & msk[s]));
        end
    endtask

    task automatic t_hold;
        @(posedge clock);
        hold_arbitration_enable <= 1'b1;
        hold_n <= 1'b0;
        repeat (8) @(posedge clock);
        #1;
        chk({bus_ctl_oe, address_data_port_oe, chip_select_lines_n}, {1'b0, 16'h0, 5'h1F});
        chk({bus_grant_ack_n_out, bus_grant_ack_n_oe}, 24'h1);
        cpu_req <= '{1'b1, 1'b0, 24'h000042, 16'h0000};
        repeat (4) @(posedge clock);
        #1;
        chk({bus_request_out_n, cpu_rsp_done}, 24'h0);
        hold_n <= 1'b1;
        for (int i = 0; i < 40 && cpu_rsp_done !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk(24'(cpu_rsp_rdata), 24'h5A3C);
        @(posedge clock);
        cpu_req.valid <= 1'b0;
        port6_bit7_direction <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk(24'(bus_grant_ack_n_oe), 24'h0);
        @(posedge clock);
        cpu_req <= '{1'b1, 1'b0, 24'h000042, 16'h0000};
        repeat (4) @(posedge clock);
        #1;
        chk({bus_request_out_n, cpu_rsp_done, bus_ctl_oe}, 24'h0);
        @(posedge clock);
        bus_grant_ack_in <= 1'b0;
        for (int i = 0; i < 40 && cpu_rsp_done !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk(24'(cpu_rsp_done), 24'h1);
        @(posedge clock);
        cpu_req.valid <= 1'b0;
    endtask

    initial begin
        #50000;
        err_total++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        chk({rd_n, wr_n, bus_grant_ack_n_oe, chip_select_lines_n}, {3'b110, 5'h1F});
        acc(1'b0, 24'h000040, 16'h0000);
        chk(24'(err_a * 16 + n_strb), 24'h10);
        t_demux();
        t_windows();
        t_bytes();
        t_ready();
        t_space();
        t_hold();
        end_sim();
    end
endmodule
`default_nettype wire

// >>> hdl/ebc_cfg.svh
/*
 Constants of the external bus controller: widths, window decode, address
 space masks, pin idle levels and the chip-select delay.
 Assumes inclusion by bare name from the package and the top module.
*/
`ifndef EBC_CFG_SVH
`define EBC_CFG_SVH
`define EBC_ADDR_W     24
`define EBC_DATA_W     16
`define EBC_WIN_N      4
`define EBC_WAIT_W     4
`define EBC_PAGE_LSB   12
`define EBC_CLK_NS     10
`define EBC_CS_DLY_NS  5
`define EBC_ASP_16M    2'h0
`define EBC_ASP_1M     2'h1
`define EBC_ASP_256K   2'h2
`define EBC_ASP_64K    2'h3
`define EBC_MASK_16M   8'hFF
`define EBC_MASK_1M    8'h0F
`define EBC_MASK_256K  8'h03
`define EBC_MASK_64K   8'h00
`define EBC_CS_IDLE    5'h1F
`define EBC_CS_ONE     5'h01
`define EBC_BUS_ALL    16'hFFFF
`define EBC_BUS_LOW    16'h00FF
`define EBC_BUS_OFF    16'h0000
`define EBC_BYTE_ZERO  8'h00
`define EBC_WAIT_ONE   4'h1
`endif

// >>> hdl/ebc_pkg.sv
/*
 Types of the external bus controller: bus modes, per-window bus
 configuration, window address select and the CPU request bundle.
 Assumes ebc_cfg.svh is on the include path.
*/
`include "ebc_cfg.svh"

package ebc_pkg;

    typedef enum logic [2:0] {
        EBC_MODE_NONE,
        EBC_MODE_DEMUX16,
        EBC_MODE_MUX16,
        EBC_MODE_MUX8,
        EBC_MODE_DEMUX8
    } ebc_mode_t;

    typedef struct packed {
        logic                    win_en;
        logic                    cs_en;
        logic                    rdy_en;
        logic                    rdy_pol;
        logic                    ale_ext;
        logic                    rw_delay;
        logic                    tri_ext;
        logic [`EBC_WAIT_W-1:0]  cycle_wait;
        ebc_mode_t               mode;
    } ebc_bus_cfg_t;

    typedef struct packed {
        logic [`EBC_ADDR_W-`EBC_PAGE_LSB-1:0] base;
        logic [3:0]                           size;
    } ebc_win_sel_t;

    typedef struct packed {
        logic                    valid;
        logic                    we;
        logic [`EBC_ADDR_W-1:0]  addr;
        logic [`EBC_DATA_W-1:0]  wdata;
    } ebc_req_t;

endpackage

// >>> hdl/ebc_top.sv
/*
 External bus controller: window decode, chip selects, multiplexed and
 demultiplexed bus cycles, READY wait and HOLD/BUS_GRANT_ACK arbitration.
 Assumes one 100 MHz clock, a CPU requester on the same clock and pins
 whose wire levels are resolved outside from the output enables.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ebc_cfg.svh"

module ebc_top
    import ebc_pkg::*;
#(
    parameter int WIN_N  = `EBC_WIN_N,
    parameter int ADDR_W = `EBC_ADDR_W
)(
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire logic                     clk_en,
    input  wire ebc_req_t                 cpu_req,
    output var  logic                     cpu_req_ready,
    output var  logic                     cpu_rsp_done,
    output var  logic                     cpu_rsp_err,
    output var  logic [`EBC_DATA_W-1:0]   cpu_rsp_rdata,
    input  wire ebc_win_sel_t [WIN_N-1:0] window_address_select,
    input  wire ebc_bus_cfg_t [WIN_N-1:0] window_bus_config,
    input  wire ebc_bus_cfg_t             default_bus_config,
    input  wire logic [1:0]               addr_space_sel,
    input  wire logic                     chip_select_early_cfg,
    input  wire logic                     hold_arbitration_enable,
    input  wire logic                     port6_bit7_direction,
    output var  logic                     ale,
    output var  logic                     rd_n,
    output var  logic                     wr_n,
    output var  logic                     bus_ctl_oe,
    output var  logic [`EBC_DATA_W-1:0]   address_data_port_out,
    output var  logic [`EBC_DATA_W-1:0]   address_data_port_oe,
    input  wire logic [`EBC_DATA_W-1:0]   address_data_port_in,
    output var  logic [`EBC_DATA_W-1:0]   dedicated_address_port,
    output var  logic [7:0]               upper_address_port,
    output var  logic [WIN_N:0]           chip_select_lines_n,
    input  wire logic                     ready_pin,
    input  wire logic                     hold_n,
    output var  logic                     bus_request_out_n,
    output var  logic                     bus_grant_ack_n_out,
    output var  logic                     bus_grant_ack_n_oe,
    input  wire logic                     bus_grant_ack_n_in
);

    localparam int CS_DLY_CYC = (`EBC_CS_DLY_NS + `EBC_CLK_NS - 1) / `EBC_CLK_NS;

    if (WIN_N < 1 || WIN_N > `EBC_WIN_N || ADDR_W != `EBC_ADDR_W || CS_DLY_CYC != 1) begin : g_bad
        $error("ebc_top: unsupported parameter values");
    end

    typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_ALE2, ST_DLY, ST_STRB, ST_END, ST_TRI, ST_HOLD} ebc_state_t;

    function automatic logic win_hit(input logic [ADDR_W-`EBC_PAGE_LSB-1:0] page, input ebc_win_sel_t w);
        logic [ADDR_W-`EBC_PAGE_LSB-1:0] diff;
        diff = (page ^ w.base) >> w.size;
        return (diff == '0);
    endfunction

    function automatic logic [2:0] pick_window(input logic [WIN_N-1:0] hits);
        logic [2:0] idx;
        idx = '0;
        for (int i = 0; i < WIN_N; i++) begin
            if (hits[i]) begin
                idx = 3'(i + 1);
            end
        end
        return idx;
    endfunction

    function automatic logic is_mux(input ebc_mode_t m);
        return (m == EBC_MODE_MUX16) || (m == EBC_MODE_MUX8);
    endfunction

    function automatic logic is_8bit(input ebc_mode_t m);
        return (m == EBC_MODE_MUX8) || (m == EBC_MODE_DEMUX8);
    endfunction

    function automatic logic [7:0] space_mask(input logic [1:0] sel);
        case (sel)
            `EBC_ASP_1M:   return `EBC_MASK_1M;
            `EBC_ASP_256K: return `EBC_MASK_256K;
            `EBC_ASP_64K:  return `EBC_MASK_64K;
            default:       return `EBC_MASK_16M;
        endcase
    endfunction

    ebc_state_t                  st_r, st_nxt;
    ebc_bus_cfg_t                cfg_r;
    logic                        we_r;
    logic [`EBC_DATA_W-1:0]      addr_lo_r, wdata_r;
    logic [WIN_N:0]              cs_tgt_r;
    logic                        cs_pend_r;
    logic [`EBC_WAIT_W:0]        wait_r, wait_nxt;
    logic                        rdy_s1_r, rdy_s2_r, hold_s1_r, hold_s2_r, bus_grant_ack_s1_r, bus_grant_ack_s2_r;
    logic [`EBC_DATA_W-1:0]      ad_s1_r, ad_s2_r;

    // Pins are asynchronous; the second stage alone feeds the logic
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {rdy_s1_r, rdy_s2_r} <= '0;
            {bus_grant_ack_s1_r, bus_grant_ack_s2_r} <= 2'h3;
            {hold_s1_r, hold_s2_r} <= 2'h3;
            {ad_s1_r, ad_s2_r} <= '0;
        end else if (clk_en) begin
            {rdy_s1_r, rdy_s2_r} <= {ready_pin, rdy_s1_r};
            {hold_s1_r, hold_s2_r} <= {hold_n, hold_s1_r};
            {bus_grant_ack_s1_r, bus_grant_ack_s2_r} <= {bus_grant_ack_n_in, bus_grant_ack_s1_r};
            {ad_s1_r, ad_s2_r} <= {address_data_port_in, ad_s1_r};
        end
    end

    wire [WIN_N-1:0] win_hits;
    for (genvar g = 0; g < WIN_N; g++) begin : g_win
        assign win_hits[g] = window_bus_config[g].win_en &&
                             win_hit(cpu_req.addr[ADDR_W-1:`EBC_PAGE_LSB], window_address_select[g]);
    end

    wire [2:0]         dec_idx = pick_window(win_hits);
    wire ebc_bus_cfg_t dec_cfg = (dec_idx == '0) ? default_bus_config : window_bus_config[dec_idx - 3'h1];
    wire [WIN_N:0]     dec_cs  = dec_cfg.cs_en ? ~((WIN_N+1)'(`EBC_CS_ONE) << dec_idx) : (WIN_N+1)'(`EBC_CS_IDLE);

    wire slave     = port6_bit7_direction;
    wire own       = !hold_arbitration_enable || !slave || !bus_grant_ack_s2_r;
    wire hold_take = (st_r == ST_IDLE) && hold_arbitration_enable && !slave && !hold_s2_r;
    wire start_ok  = (st_r == ST_IDLE) && cpu_req.valid && own && !hold_take && !cpu_rsp_done;
    wire no_bus    = start_ok && (dec_cfg.mode == EBC_MODE_NONE);
    wire accept    = start_ok && (dec_cfg.mode != EBC_MODE_NONE);
    wire rdy_ok    = !cfg_r.rdy_en || (rdy_s2_r == cfg_r.rdy_pol);
    wire mux_r     = is_mux(cfg_r.mode);
    wire nar_r     = is_8bit(cfg_r.mode);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (hold_take) begin
                    st_nxt = ST_HOLD;
                end else if (accept) begin
                    st_nxt = ST_ALE;
                end
            end
            ST_ALE:  st_nxt = cfg_r.ale_ext ? ST_ALE2 : (cfg_r.rw_delay ? ST_DLY : ST_STRB);
            ST_ALE2: st_nxt = cfg_r.rw_delay ? ST_DLY : ST_STRB;
            ST_DLY:  st_nxt = ST_STRB;
            ST_STRB: begin
                if (wait_r == '0 && rdy_ok) begin
                    st_nxt = ST_END;
                end
            end
            ST_END:  st_nxt = cfg_r.tri_ext ? ST_TRI : ST_IDLE;
            ST_TRI:  st_nxt = ST_IDLE;
            ST_HOLD: begin
                if (hold_s2_r) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    wire enter_strb = (st_nxt == ST_STRB) && (st_r != ST_STRB);
    always_comb begin
        wait_nxt = wait_r;
        if (enter_strb) begin
            wait_nxt = {1'b0, cfg_r.cycle_wait} + (`EBC_WAIT_W+1)'(`EBC_WAIT_ONE);
        end else if (st_r == ST_STRB && wait_r != '0) begin
            wait_nxt = wait_r - (`EBC_WAIT_W+1)'(`EBC_WAIT_ONE);
        end
    end

    wire addr_ph  = (st_nxt == ST_ALE) || (st_nxt == ST_ALE2);
    wire data_ph  = (st_nxt == ST_DLY) || (st_nxt == ST_STRB) || (st_nxt == ST_END);
    wire [`EBC_DATA_W-1:0] lane = nar_r ? `EBC_BUS_LOW : `EBC_BUS_ALL;
    // mux_r holds is_mux of the new window only after accept, so the address phase decodes live
    wire acc_mux  = is_mux(dec_cfg.mode);
    wire [`EBC_DATA_W-1:0] ad_oe_nxt =
        !own || st_nxt == ST_HOLD ? `EBC_BUS_OFF :
        accept ? (acc_mux ? `EBC_BUS_ALL : `EBC_BUS_OFF) :
        (addr_ph && mux_r) ? `EBC_BUS_ALL :
        (data_ph && we_r) ? lane : `EBC_BUS_OFF;
    wire [`EBC_DATA_W-1:0] ad_out_nxt =
        accept ? cpu_req.addr[`EBC_DATA_W-1:0] : (addr_ph ? address_data_port_out : wdata_r);
    wire [WIN_N:0] cs_nxt =
        hold_take ? (WIN_N+1)'(`EBC_CS_IDLE) :
        (accept && chip_select_early_cfg) ? dec_cs :
        cs_pend_r ? cs_tgt_r : chip_select_lines_n;
    wire [`EBC_DATA_W-1:0] rdata_nxt = nar_r ? {`EBC_BYTE_ZERO, ad_s2_r[7:0]} : ad_s2_r;
    wire brq_nxt = !(hold_arbitration_enable &&
                     ((!slave && st_nxt == ST_HOLD && cpu_req.valid) ||
                      (slave && (cpu_req.valid || st_r != ST_IDLE))));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= ST_IDLE;
            cfg_r <= '0;
            {we_r, addr_lo_r, wdata_r, cs_pend_r, wait_r} <= '0;
            cs_tgt_r <= (WIN_N+1)'(`EBC_CS_IDLE);
        end else if (clk_en) begin
            st_r <= st_nxt;
            wait_r <= wait_nxt;
            cs_pend_r <= accept && !chip_select_early_cfg;
            if (accept) begin
                cfg_r <= dec_cfg;
                we_r <= cpu_req.we;
                addr_lo_r <= cpu_req.addr[`EBC_DATA_W-1:0];
                wdata_r <= cpu_req.wdata;
                cs_tgt_r <= dec_cs;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {cpu_req_ready, cpu_rsp_done, cpu_rsp_err, cpu_rsp_rdata} <= '0;
            {ale, bus_grant_ack_n_oe, address_data_port_out, address_data_port_oe} <= '0;
            {dedicated_address_port, upper_address_port} <= '0;
            {rd_n, wr_n, bus_ctl_oe, bus_request_out_n, bus_grant_ack_n_out} <= 5'h1F;
            chip_select_lines_n <= (WIN_N+1)'(`EBC_CS_IDLE);
        end else if (clk_en) begin
            cpu_req_ready <= (st_nxt == ST_IDLE);
            cpu_rsp_done <= no_bus || (st_r == ST_END && !cfg_r.tri_ext) || (st_r == ST_TRI);
            cpu_rsp_err <= no_bus;
            if (st_r == ST_END && !we_r) begin
                cpu_rsp_rdata <= rdata_nxt;
            end
            ale <= addr_ph;
            rd_n <= !(st_nxt == ST_STRB && !we_r);
            wr_n <= !(st_nxt == ST_STRB && we_r);
            bus_ctl_oe <= own && (st_nxt != ST_HOLD);
            address_data_port_out <= ad_out_nxt;
            address_data_port_oe <= ad_oe_nxt;
            if (accept && !acc_mux) begin
                dedicated_address_port <= cpu_req.addr[`EBC_DATA_W-1:0];
            end
            if (accept) begin
                upper_address_port <= cpu_req.addr[ADDR_W-1:`EBC_DATA_W] & space_mask(addr_space_sel);
            end
            chip_select_lines_n <= cs_nxt;
            bus_request_out_n <= brq_nxt;
            bus_grant_ack_n_out <= !(st_nxt == ST_HOLD);
            bus_grant_ack_n_oe <= hold_arbitration_enable && !slave;
        end
    end

    // Helper: strobe length in cycles, checked against the programmed wait
    logic [`EBC_WAIT_W+1:0] strb_len_r;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            strb_len_r <= '0;
        end else if (clk_en) begin
            strb_len_r <= (!rd_n || !wr_n) ? strb_len_r + 1'b1 : '0;
        end
    end

    property p_single_chip;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        no_bus |=> cpu_rsp_done && cpu_rsp_err && ale == 1'b0;
    endproperty
    a_single_chip: assert property (p_single_chip) else $error("single-chip access drove the bus");

    property p_demux_addr;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        accept && !acc_mux |=> dedicated_address_port == $past(cpu_req.addr[`EBC_DATA_W-1:0])
                               && address_data_port_oe == `EBC_BUS_OFF;
    endproperty
    a_demux_addr: assert property (p_demux_addr) else $error("demux address not on dedicated port");

    property p_narrow_lane;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        nar_r && st_r != ST_IDLE && st_r != ST_ALE && st_r != ST_ALE2 |-> address_data_port_oe[15:8] == '0;
    endproperty
    a_narrow_lane: assert property (p_narrow_lane) else $error("8-bit bus drove the high byte");

    property p_mux_addr;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        accept && acc_mux |=> ale && address_data_port_out == $past(cpu_req.addr[`EBC_DATA_W-1:0])
                              && address_data_port_oe == `EBC_BUS_ALL;
    endproperty
    a_mux_addr: assert property (p_mux_addr) else $error("mux address phase wrong");

    property p_strobe_len;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        st_r == ST_END && !cfg_r.rdy_en |-> strb_len_r == {2'b00, cfg_r.cycle_wait} + 2'd2;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length differs from wait setting");

    property p_priority;
        @(posedge clock) disable iff (sys_rst)
        (WIN_N == 4 && win_hits[3] |-> dec_idx == 3'd4) and
        (win_hits[1] && !win_hits[2] && !(WIN_N == 4 && win_hits[3]) |-> dec_idx == 3'd2) and
        (win_hits == '0 |-> dec_idx == 3'd0);
    endproperty
    a_priority: assert property (p_priority) else $error("window precedence broken");

    property p_cs_onehot;
        @(posedge clock) disable iff (sys_rst)
        $countones(~chip_select_lines_n) <= 1;
    endproperty
    a_cs_onehot: assert property (p_cs_onehot) else $error("more than one chip select active");

    property p_ready_wait;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        st_r == ST_STRB && cfg_r.rdy_en && rdy_s2_r != cfg_r.rdy_pol |=> st_r == ST_STRB;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("cycle ended without READY");

    property p_hold;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        hold_take |=> !bus_ctl_oe && !bus_grant_ack_n_out && address_data_port_oe == '0;
    endproperty
    a_hold: assert property (p_hold) else $error("bus not released on hold");

    property p_role;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        hold_arbitration_enable |=> bus_grant_ack_n_oe == !$past(port6_bit7_direction);
    endproperty
    a_role: assert property (p_role) else $error("grant pin direction wrong");

    property p_upper;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        accept |=> (upper_address_port & ~space_mask($past(addr_space_sel))) == '0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper address beyond space");

    property p_cs_late;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        accept && !chip_select_early_cfg |=> ale && chip_select_lines_n == $past(chip_select_lines_n)
                                             ##1 chip_select_lines_n == cs_tgt_r;
    endproperty
    a_cs_late: assert property (p_cs_late) else $error("chip select not delayed");

    property p_cs_early;
        @(posedge clock) disable iff (sys_rst || !clk_en)
        accept && chip_select_early_cfg |=> ale && chip_select_lines_n == cs_tgt_r;
    endproperty
    a_cs_early: assert property (p_cs_early) else $error("early chip select late");

    property p_cov_read;
        @(posedge clock) disable iff (sys_rst) cpu_rsp_done && !cpu_rsp_err && !we_r;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_write;
        @(posedge clock) disable iff (sys_rst) cpu_rsp_done && we_r && mux_r;
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_hold;
        @(posedge clock) disable iff (sys_rst) st_r == ST_HOLD ##1 st_r == ST_IDLE;
    endproperty
    c_cov_hold: cover property (p_cov_hold);

    property p_cov_ready;
        @(posedge clock) disable iff (sys_rst) st_r == ST_STRB && wait_r == '0 && !rdy_ok;
    endproperty
    c_cov_ready: cover property (p_cov_ready);

endmodule
`default_nettype wire
